// file: core/ccstt_top.sv
// Core clock stop and thermal trip control, top level.
`timescale 1ns/1ps
`default_nettype none
`include "ccstt_params.svh"
// What this block does
// [R01] Asserted stop-clock request moves the core into the clock-halt state.
// [R02] Entering clock-halt issues one acknowledge pulse toward the bus unit.
// [R03] In clock-halt, core clocks are gated; bus and interrupt units keep running.
// [R04] Snooping and interrupt servicing stay enabled throughout clock-halt.
// [R05] Removing the request re-enables all clocks and resumes execution.
// [R06] Stop request is asynchronous and never gates the bus clock.
// [R07] Over-temperature asserts thermal trip and stops every internal clock.
// [R08] Thermal trip drive is enabled within 10 us after power-good rises.
// [R09] Thermal trip drive is disabled whenever power-good is low.
// [R10] Thermal trip stays latched until power-good drops.
// [R11] Still hot after power-good returns: trip reasserts within 10 us.
// [R12] Platform removes core supply after seeing thermal trip.
// [R13] Platform holds power-good low until clocks and supplies are stable.
// [R14] Stop request passes a two-flop synchroniser before use.
module ccstt_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic stop_clock_request_n,
  input wire logic power_good,
  input wire logic overTempIn,
  output logic thermal_trip_n_o,
  output logic thermal_trip_n_oe_n,
  output logic stopGrantAck,
  output logic coreClkEn,
  output logic busUnitClkEn,
  output logic interruptClkEn,
  output logic snoopEn,
  output logic executeEn,
  output ccstt_pkg::ccstt_clk_state_t clkState
);
  import ccstt_pkg::*;

  ccstt_sync_if syncBus ();
  logic tripActive;
  logic tripDriveEn;
  ccstt_clk_state_t state_r;
  ccstt_clk_state_t state_nxt;

  ccstt_sync u_sync (
    .clk(clk),
    .reset(reset),
    .stop_clock_request_n(stop_clock_request_n),
    .power_good(power_good),
    .overTempIn(overTempIn),
    .syncOut(syncBus.src)
  ); // [R14]

  ccstt_trip u_trip (
    .clk(clk),
    .reset(reset),
    .syncIn(syncBus.dst),
    .tripActive(tripActive),
    .tripDriveEn(tripDriveEn)
  );

  // The request only steers the state; the bus clock never passes through here.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      CS_RUN:
        if (syncBus.stopReq)
          state_nxt = CS_ENTER; // [R01]
      CS_ENTER:
        state_nxt = syncBus.stopReq ? CS_HALT : CS_RUN;
      CS_HALT:
        if (!syncBus.stopReq)
          state_nxt = CS_RUN; // [R05]
      default:
        state_nxt = CS_RUN;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      state_r <= CS_RUN;
    else
      state_r <= state_nxt;
  end

  wire haltNext = (state_nxt != CS_RUN);
  wire ackNext = (state_r == CS_RUN) && (state_nxt == CS_ENTER); // [R02]
  wire tripOn = tripActive; // [R07]
  wire tripOeNext = !tripDriveEn; // [R08] [R09]

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      stopGrantAck <= 1'b0;
      coreClkEn <= 1'b0;
      busUnitClkEn <= 1'b0;
      interruptClkEn <= 1'b0;
      snoopEn <= 1'b0;
      executeEn <= 1'b0;
      thermal_trip_n_o <= 1'b1;
      thermal_trip_n_oe_n <= 1'b1;
      clkState <= CS_RUN;
    end
    else
    begin
      stopGrantAck <= ackNext && !tripOn; // [R02]
      coreClkEn <= !haltNext && !tripOn; // [R03] [R07]
      busUnitClkEn <= !tripOn; // [R03] [R06]
      interruptClkEn <= !tripOn; // [R03]
      snoopEn <= !tripOn; // [R04]
      executeEn <= !haltNext && !tripOn; // [R05] [R07]
      thermal_trip_n_o <= !tripOn; // [R10] [R11]
      thermal_trip_n_oe_n <= tripOeNext;
      clkState <= state_nxt;
    end
  end
endmodule // ccstt_top
`default_nettype wire

// file: common/ccstt_params.svh
// Timing counts and counter width for the clock stop and thermal trip control.
`ifndef CCSTT_PARAMS_SVH
`define CCSTT_PARAMS_SVH
`define CCSTT_CLK_MHZ 40
`define CCSTT_TRIP_ENABLE_US 10
`define CCSTT_TRIP_ENABLE_CYCLES ((`CCSTT_TRIP_ENABLE_US * `CCSTT_CLK_MHZ) - 8)
`define CCSTT_CNT_W 9
`define CCSTT_ACK_PULSE_CYCLES 1
`endif

// file: common/ccstt_pkg.sv
// Types shared by the clock stop and thermal trip control.
package ccstt_pkg;
  typedef enum logic [1:0] {
    CS_RUN,
    CS_ENTER,
    CS_HALT
  } ccstt_clk_state_t;
endpackage

// file: common/ccstt_sync_if.sv
// Interface carrying synchronised pin levels between modules.
`timescale 1ns/1ps
`default_nettype none
interface ccstt_sync_if;
  logic stopReq;
  logic powerGood;
  logic overTemp;
  modport src (output stopReq, output powerGood, output overTemp);
  modport dst (input stopReq, input powerGood, input overTemp);
endinterface
`default_nettype wire

// file: core/ccstt_sync.sv
// Two-flop synchronisers for asynchronous pin inputs.
`timescale 1ns/1ps
`default_nettype none
module ccstt_sync (
  input wire logic clk,
  input wire logic reset,
  input wire logic stop_clock_request_n,
  input wire logic power_good,
  input wire logic overTempIn,
  ccstt_sync_if.src syncOut
);
  logic [2:0] stage1_r;
  logic [2:0] stage2_r;
  wire [2:0] rawIn = {overTempIn, power_good, ~stop_clock_request_n};

  genvar i;
  generate
    for (i = 0; i < 3; i++)
    begin : g_sync
      always_ff @(posedge clk)
      begin
        if (reset)
        begin
          stage1_r[i] <= 1'b0;
          stage2_r[i] <= 1'b0;
        end
        else
        begin
          stage1_r[i] <= rawIn[i];
          stage2_r[i] <= stage1_r[i];
        end
      end
    end
  endgenerate

  assign syncOut.stopReq = stage2_r[0];
  assign syncOut.powerGood = stage2_r[1];
  assign syncOut.overTemp = stage2_r[2];
endmodule // ccstt_sync

// file: core/ccstt_trip.sv
// Thermal trip latch with power-good arming window.
`timescale 1ns/1ps
`default_nettype none
`include "ccstt_params.svh"
module ccstt_trip (
  input wire logic clk,
  input wire logic reset,
  ccstt_sync_if.dst syncIn,
  output logic tripActive,
  output logic tripDriveEn
);
  logic [`CCSTT_CNT_W-1:0] armCnt_r;
  logic armed_r;
  logic tripLatch_r;
  wire armDone = (armCnt_r == `CCSTT_CNT_W'(`CCSTT_TRIP_ENABLE_CYCLES));
  wire tripSet = armed_r && syncIn.overTemp;

  always_ff @(posedge clk)
  begin
    if (reset || !syncIn.powerGood)
    begin
      armCnt_r <= '0;
      armed_r <= 1'b0;
      tripLatch_r <= 1'b0;
    end
    else
    begin
      if (!armDone)
        armCnt_r <= armCnt_r + `CCSTT_CNT_W'(1);
      armed_r <= armed_r | armDone;
      tripLatch_r <= tripLatch_r | tripSet;
    end
  end

  assign tripActive = tripLatch_r;
  assign tripDriveEn = armed_r;
endmodule // ccstt_trip

// file: testbench/ccstt_properties.sv
// Port assertions for the clock stop and thermal trip control.
`timescale 1ns/1ps
`default_nettype none
module ccstt_properties (
  input wire logic clk,
  input wire logic reset,
  input wire logic stop_clock_request_n,
  input wire logic power_good,
  input wire logic thermal_trip_n_o,
  input wire logic thermal_trip_n_oe_n,
  input wire logic stopGrantAck,
  input wire logic coreClkEn,
  input wire logic snoopEn
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_ack; stopGrantAck |-> !$past(stop_clock_request_n, 2); endproperty
  a_ack: assert property (p_ack) else $error("ack");
  property p_one; stopGrantAck |=> !stopGrantAck; endproperty
  a_one: assert property (p_one) else $error("ack");
  property p_hlt; stopGrantAck |-> !coreClkEn ##1 !coreClkEn; endproperty
  a_hlt: assert property (p_hlt) else $error("halt");
  property p_snp;
    !coreClkEn && thermal_trip_n_o && $past(thermal_trip_n_o) && !$past(reset) |-> snoopEn;
  endproperty
  a_snp: assert property (p_snp) else $error("snoop");
  property p_res; $rose(coreClkEn) |-> $past(stop_clock_request_n, 2); endproperty
  a_res: assert property (p_res) else $error("resume");
  property p_trp; !thermal_trip_n_o |-> !coreClkEn && !snoopEn; endproperty
  a_trp: assert property (p_trp) else $error("trip");
  property p_off; $fell(power_good) |-> ##[0:4] thermal_trip_n_oe_n; endproperty
  a_off: assert property (p_off) else $error("drive");
  property p_arm; $rose(power_good) |-> ##[1:400] (!thermal_trip_n_oe_n || !power_good); endproperty
  a_arm: assert property (p_arm) else $error("arm");
endmodule // ccstt_properties
`default_nettype wire

// file: testbench/ccstt_platform.sv
// Platform model that removes power after a thermal trip.
`timescale 1ns/1ps
`default_nettype none
module ccstt_platform (
  input wire logic clk,
  input wire logic pgEnable,
  input wire logic tripPin,
  output var logic power_good
);
  initial power_good = 1'h0;
  always @(posedge clk) power_good <= pgEnable && tripPin;
endmodule // ccstt_platform
`default_nettype wire

// file: testbench/ccstt_top_tb.sv
// Self-checking bench for the clock stop and thermal trip control.
`timescale 1ns/1ps
`default_nettype none
module ccstt_top_tb;
  logic clk = 1'h0, reset = 1'h1, stop_clock_request_n = 1'h1, overTempIn = 1'h0, en = 1'h0;
  logic power_good, thermal_trip_n_o, thermal_trip_n_oe_n, stopGrantAck, coreClkEn, snoopEn;
  logic busUnitClkEn, interruptClkEn, executeEn;
  ccstt_pkg::ccstt_clk_state_t clkState;
  wire logic pin = thermal_trip_n_oe_n | thermal_trip_n_o;
  int err_count = 0, n_compared = 0, cyc = 0, acks = 0, k;
  always #12.5 clk = ~clk;
  ccstt_top dut_u (.*);
  ccstt_platform plat_u (.clk(clk), .pgEnable(en), .tripPin(pin), .power_good(power_good));
  task automatic wrap_up;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t %h %h", $time, got, exp);
    end
  endtask
  always @(negedge clk)
  begin
    cyc++;
    if (stopGrantAck === 1'h1)
      acks++;
    if (cyc == 4000)
    begin
      err_count++;
      wrap_up();
    end
  end
  initial
  begin
    k = $urandom(29);
    repeat (20) @(posedge clk);
    reset <= 1'h0;
    en <= 1'h1;
    repeat (420) @(negedge clk);
    chk({thermal_trip_n_oe_n, busUnitClkEn, interruptClkEn}, 8'h3);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk) stop_clock_request_n <= 1'h0;
      repeat (5 + $urandom % 8) @(negedge clk);
      chk({coreClkEn, executeEn, snoopEn, clkState}, {3'h1, ccstt_pkg::CS_HALT});
      @(posedge clk) stop_clock_request_n <= 1'h1;
      repeat (5 + $urandom % 8) @(negedge clk);
      chk({coreClkEn, executeEn}, 8'h3);
    end
    chk(acks[7:0], 8'h8);
    @(posedge clk) overTempIn <= 1'h1;
    for (k = 0; k < 20 && pin === 1'h1; k++) @(negedge clk);
    chk({pin, coreClkEn, busUnitClkEn}, 8'h0);
    repeat (6) @(negedge clk);
    chk({pin, thermal_trip_n_oe_n}, 8'h3);
    for (k = 0; k < 420 && pin === 1'h1; k++) @(negedge clk);
    chk(pin, 8'h0);
    wrap_up();
  end
endmodule // ccstt_top_tb
bind ccstt_top ccstt_properties chk_u (.*);
`default_nettype wire
